// [sbcl_pkg.sv]
package sbcl_pkg;
  // ==========================================================
  // Command encoding: {ras, cas, we} after chip select low
  // ==========================================================
  localparam logic [2:0] CMD_NOP = 3'h7;
  localparam logic [2:0] CMD_ACT = 3'h3;
  localparam logic [2:0] CMD_RD = 3'h5;
  localparam logic [2:0] CMD_WR = 3'h4;
  localparam logic [2:0] CMD_BST = 3'h6;
  localparam logic [2:0] CMD_PRE = 3'h2;
  localparam logic [2:0] CMD_REF = 3'h1;
  localparam logic [2:0] CMD_LMR = 3'h0;

  // ==========================================================
  // Geometry and timing
  // ==========================================================
  localparam int NUM_BANKS = 4;
  localparam int CLK_PERIOD_NS = 100;
  localparam int PRECHARGE_TIME_NS = 15;
  localparam int ACTIVATE_TO_ACCESS_TIME_NS = 15;
  localparam int REFRESH_CYCLE_TIME_NS = 72;
  localparam int MODE_REGISTER_TIME_NS = 10;
  localparam int BURST_CYCLES = 4;
  localparam int CNT_W = 8;

  // Least times round up, never below one cycle
  function automatic int cyc(input int ns);
    int c;
    c = (ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    return (c < 1) ? 1 : c;
  endfunction

  localparam int PRECHARGE_CYC = cyc(PRECHARGE_TIME_NS);
  localparam int ACTIVATE_CYC = cyc(ACTIVATE_TO_ACCESS_TIME_NS);
  localparam int REFRESH_CYC = cyc(REFRESH_CYCLE_TIME_NS);
  localparam int MODE_REG_CYC = cyc(MODE_REGISTER_TIME_NS);

  // Per-bank state
  typedef enum logic [2:0] {
    SBCL_IDLE, SBCL_ACTIVATING, SBCL_ACTIVE, SBCL_READ, SBCL_WRITE,
    SBCL_PRECHARGING, SBCL_READ_AP, SBCL_WRITE_AP
  } sbcl_bank_e;

  // Device-wide state
  typedef enum logic [2:0] {
    SBCL_DEV_NORMAL, SBCL_DEV_REFRESH, SBCL_DEV_MODE_REG,
    SBCL_DEV_PRE_ALL, SBCL_DEV_DEEP_PD
  } sbcl_dev_e;
endpackage

// [sbcl_bank_if.sv]
`timescale 1ns/1ns
`default_nettype none
// Command broadcast from the decoder to one bank tracker
interface sbcl_bank_if;
  logic hit;
  logic [2:0] cmd;
  logic autoPre;
  logic preAll;
  logic burstEnd;
  logic [2:0] state;
  logic busy;
  modport ctrl (output hit, cmd, autoPre, preAll, burstEnd,
    input state, busy);
  modport bank (input hit, cmd, autoPre, preAll, burstEnd,
    output state, busy);
endinterface
`default_nettype wire

// [sbcl_bank_fsm.sv]
`timescale 1ns/1ns
`default_nettype none
// ============================================================
// One bank's state machine with its minimum-time counter
// ============================================================
module sbcl_bank_fsm #(
  parameter int PRE_CYC = 1,
  parameter int ACT_CYC = 1
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic rstn,
  input wire logic ce,
  // Command port
  sbcl_bank_if.bank bus
);
  import sbcl_pkg::*;

  sbcl_bank_e state;
  logic [CNT_W-1:0] timer;

  assign bus.state = state;
  assign bus.busy = (state == SBCL_ACTIVATING) ||
    (state == SBCL_PRECHARGING) || (state == SBCL_READ_AP) ||
    (state == SBCL_WRITE_AP);

  // Bank state and timer; illegal commands are left unexecuted
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      state <= SBCL_IDLE;
      timer <= '0;
    end else if (ce) begin
      if (timer != '0) begin
        timer <= timer - 1'b1;
      end
      unique case (state)
        SBCL_IDLE: begin
          if (bus.hit && bus.cmd == CMD_ACT) begin
            state <= SBCL_ACTIVATING;
            timer <= CNT_W'(ACT_CYC - 1);
          end
        end
        SBCL_ACTIVATING, SBCL_PRECHARGING: begin
          // Finishes on its own once the time is met
          if (timer == '0) begin
            state <= (state == SBCL_ACTIVATING) ? SBCL_ACTIVE : SBCL_IDLE;
          end
        end
        SBCL_READ_AP, SBCL_WRITE_AP: begin
          // Busy from registration until precharge time is met
          if (timer == '0) begin
            state <= SBCL_IDLE;
          end
        end
        SBCL_ACTIVE, SBCL_READ, SBCL_WRITE: begin
          if (bus.hit && (bus.cmd == CMD_RD || bus.cmd == CMD_WR)) begin
            if (bus.autoPre) begin
              state <= (bus.cmd == CMD_RD) ? SBCL_READ_AP : SBCL_WRITE_AP;
              timer <= CNT_W'(BURST_CYCLES + PRE_CYC - 1);
            end else begin
              state <= (bus.cmd == CMD_RD) ? SBCL_READ : SBCL_WRITE;
              timer <= CNT_W'(BURST_CYCLES - 1);
            end
          end else if ((bus.hit || bus.preAll) && bus.cmd == CMD_PRE) begin
            // Truncates any open burst
            state <= SBCL_PRECHARGING;
            timer <= CNT_W'(PRE_CYC - 1);
          end else if (bus.burstEnd && state != SBCL_ACTIVE) begin
            state <= SBCL_ACTIVE;
          end else if (state != SBCL_ACTIVE && timer == '0) begin
            state <= SBCL_ACTIVE;
          end
        end
      endcase
    end
  end
endmodule
`default_nettype wire

// [sbcl_command_legality.sv]
`timescale 1ns/1ns
`default_nettype none
// Behaviour
// - Burst-terminate with clock enable low, all banks idle, enters deepest power-down.
// - Deepest power-down loses array contents; data flagged invalid.
// - Chip select high or all strobes high: no new operation.
// - Idle bank takes activate; refresh and mode load are device-wide.
// - Row-active bank takes read, write and precharge.
// - Read burst takes read, write, precharge, burst terminate.
// - Write burst takes read, write or truncating precharge.
// - Bank states follow precharge, activate and burst completion times.
// - Auto-precharge access keeps bank busy until precharge time met.
// - Burst terminate ends the latest read, whichever bank.
// - Idle bank n does not restrict commands to bank m.
// - Busy bank n allows activate, read, write, precharge elsewhere.
// - New burst to another bank replaces a running burst without auto-precharge.
// - Auto-precharge bit high on read or write closes the row.
// - Auto-precharge bit high on precharge selects all banks.
module sbcl_command_legality #(
  parameter int PRE_CYC = sbcl_pkg::PRECHARGE_CYC,
  parameter int ACT_CYC = sbcl_pkg::ACTIVATE_CYC,
  parameter int RFC_CYC = sbcl_pkg::REFRESH_CYC,
  parameter int MRD_CYC = sbcl_pkg::MODE_REG_CYC
) (
  // Clock, reset and freeze
  input wire logic mclk,
  input wire logic rstn,
  input wire logic ce,
  // Command pins, active low strobes
  input wire logic memClkEn,
  input wire logic chipSelN,
  input wire logic rasN,
  input wire logic casN,
  input wire logic weN,
  input wire logic bankSelectLow,
  input wire logic bankSelectHigh,
  input wire logic autoPrechargeAddressBit,
  // Status
  output logic [4*3-1:0] bankState,
  output logic [2:0] deviceState,
  output logic burstBank,
  output logic [1:0] lastReadBank,
  output logic dataInvalid,
  output logic protocolError,
  output logic cmdAccepted
);
  import sbcl_pkg::*;

  // ==========================================================
  // Command decode
  // ==========================================================
  logic cePrev;
  sbcl_dev_e devState;
  logic [CNT_W-1:0] devTimer;
  logic [1:0] readBank;
  logic readValid;
  logic [1:0] bankAddr;
  logic [2:0] cmd;
  logic cmdValid;
  logic anyBusy;
  logic allIdle;
  logic anyBurst;
  logic legal;
  logic [NUM_BANKS-1:0] busyVec;
  logic [NUM_BANKS-1:0] idleVec;
  logic [NUM_BANKS-1:0] burstVec;
  logic [NUM_BANKS-1:0] preOkVec;
  // Bank states gathered so they can be picked by a run-time index
  logic [NUM_BANKS-1:0][2:0] stateArr;

  sbcl_bank_if bif [NUM_BANKS] ();

  assign bankAddr = {bankSelectHigh, bankSelectLow};
  assign cmd = {rasN, casN, weN};
  // Deselect or all strobes high: nothing new happens
  // Table commands need clock enable high now and before
  assign cmdValid = !chipSelN && cmd != CMD_NOP && memClkEn && cePrev &&
    devState == SBCL_DEV_NORMAL;

  // Per-bank precharge test, idle included, used only for all-bank precharge
  function automatic logic pre_ok(input logic [2:0] s);
    return s == SBCL_ACTIVE || s == SBCL_READ || s == SBCL_WRITE ||
      s == SBCL_IDLE;
  endfunction

  // ==========================================================
  // Four bank machines
  // ==========================================================
  generate
    for (genvar b = 0; b < NUM_BANKS; b++) begin : g_bank
      // Bank-select decode
      assign bif[b].hit = cmdValid && legal && bankAddr == 2'(b);
      assign bif[b].cmd = cmd;
      assign bif[b].autoPre = autoPrechargeAddressBit;
      // All-bank precharge ignores bank select
      assign bif[b].preAll = cmdValid && legal && autoPrechargeAddressBit;
      // Ends this bank's open burst: a burst terminate aimed at the
      // latest read, or a new burst to another bank
      assign bif[b].burstEnd = cmdValid && legal &&
        ((cmd == CMD_BST && readValid && readBank == 2'(b)) ||
        ((cmd == CMD_RD || cmd == CMD_WR) && bankAddr != 2'(b)));
      assign stateArr[b] = bif[b].state;
      assign busyVec[b] = bif[b].busy;
      assign idleVec[b] = bif[b].state == SBCL_IDLE;
      assign burstVec[b] = bif[b].state == SBCL_READ ||
        bif[b].state == SBCL_WRITE || bif[b].state == SBCL_READ_AP ||
        bif[b].state == SBCL_WRITE_AP;
      assign preOkVec[b] = pre_ok(bif[b].state);
      sbcl_bank_fsm #(.PRE_CYC(PRE_CYC), .ACT_CYC(ACT_CYC)) u_bank (
        .mclk(mclk),
        .rstn(rstn),
        .ce(ce),
        .bus(bif[b])
      );
    end
  endgenerate

  assign anyBusy = |busyVec;
  assign allIdle = &idleVec;
  assign anyBurst = |burstVec;

  // ==========================================================
  // Legality of the command against the addressed bank
  // ==========================================================
  logic [2:0] tgtState;
  always_comb begin
    tgtState = 3'h0;
    for (int i = 0; i < NUM_BANKS; i++) begin
      if (bankAddr == 2'(i)) begin
        tgtState = stateArr[i];
      end
    end
  end

  // Other banks never restrict bank m
  always_comb begin
    legal = 1'b0;
    unique case (cmd)
      CMD_ACT: legal = tgtState == SBCL_IDLE;
      CMD_RD, CMD_WR: begin
        legal = tgtState == SBCL_ACTIVE || tgtState == SBCL_READ ||
          tgtState == SBCL_WRITE;
      end
      CMD_PRE: begin
        if (autoPrechargeAddressBit) begin
          legal = (&preOkVec) && !anyBusy;
        end else begin
          legal = tgtState == SBCL_ACTIVE || tgtState == SBCL_READ ||
            tgtState == SBCL_WRITE;
        end
      end
      CMD_BST: legal = readValid;
      CMD_REF, CMD_LMR: legal = allIdle && !anyBurst;
      default: legal = 1'b0;
    endcase
  end

  // ==========================================================
  // Clock-enable history
  // ==========================================================
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      cePrev <= 1'b0;
    end else if (ce) begin
      cePrev <= memClkEn;
    end
  end

  // ==========================================================
  // Device-wide state: refresh, mode load, precharge all, DEEPEST_POWER_DOWN
  // ==========================================================
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      devState <= SBCL_DEV_NORMAL;
      devTimer <= '0;
    end else if (ce) begin
      if (devTimer != '0) begin
        devTimer <= devTimer - 1'b1;
      end
      unique case (devState)
        SBCL_DEV_NORMAL: begin
          if (!chipSelN && cmd == CMD_BST && !memClkEn && cePrev &&
              allIdle) begin
            devState <= SBCL_DEV_DEEP_PD;
          end else if (cmdValid && legal && cmd == CMD_REF) begin
            devState <= SBCL_DEV_REFRESH;
            devTimer <= CNT_W'(RFC_CYC - 1);
          end else if (cmdValid && legal && cmd == CMD_LMR) begin
            devState <= SBCL_DEV_MODE_REG;
            devTimer <= CNT_W'(MRD_CYC - 1);
          end else if (cmdValid && legal && cmd == CMD_PRE &&
              autoPrechargeAddressBit) begin
            devState <= SBCL_DEV_PRE_ALL;
            devTimer <= CNT_W'(PRE_CYC - 1);
          end
        end
        SBCL_DEV_REFRESH, SBCL_DEV_MODE_REG, SBCL_DEV_PRE_ALL: begin
          // Returns to all-banks-idle when the time is met
          if (devTimer == '0) begin
            devState <= SBCL_DEV_NORMAL;
          end
        end
        SBCL_DEV_DEEP_PD: begin
          // Leaves only by clock enable rising; needs full init after
          if (memClkEn) begin
            devState <= SBCL_DEV_NORMAL;
          end
        end
      endcase
    end
  end

  // ==========================================================
  // Latest read tracking; a newer burst replaces it
  // ==========================================================
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      readBank <= 2'h0;
      readValid <= 1'b0;
    end else if (ce) begin
      if (cmdValid && legal && cmd == CMD_RD &&
          !autoPrechargeAddressBit) begin
        readBank <= bankAddr;
        readValid <= 1'b1;
      end else if (cmdValid && legal &&
          (cmd == CMD_BST || cmd == CMD_WR ||
          (cmd == CMD_RD && autoPrechargeAddressBit))) begin
        readValid <= 1'b0;
      end else if (stateArr[readBank] != SBCL_READ) begin
        readValid <= 1'b0;
      end
    end
  end

  // ==========================================================
  // Status outputs, all registered
  // ==========================================================
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      bankState <= '0;
      deviceState <= 3'h0;
      burstBank <= 1'b0;
      lastReadBank <= 2'h0;
    end else if (ce) begin
      for (int i = 0; i < NUM_BANKS; i++) begin
        bankState[i*3 +: 3] <= stateArr[i];
      end
      deviceState <= devState;
      burstBank <= anyBurst;
      lastReadBank <= readBank;
    end
  end

  // Contents lost on deep power-down, cleared by mode load after init
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      dataInvalid <= 1'b1;
    end else if (ce) begin
      if (devState == SBCL_DEV_DEEP_PD) begin
        dataInvalid <= 1'b1;
      end else if (cmdValid && legal && cmd == CMD_LMR) begin
        dataInvalid <= 1'b0;
      end
    end
  end

  // Flag rather than execute anything out of the tables
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      protocolError <= 1'b0;
      cmdAccepted <= 1'b0;
    end else if (ce) begin
      // Any command during device busy, or illegal
      protocolError <= !chipSelN && cmd != CMD_NOP && memClkEn && cePrev &&
        (devState != SBCL_DEV_NORMAL || !legal);
      cmdAccepted <= cmdValid && legal;
    end
  end
endmodule
`default_nettype wire

// [sbcl_legality_monitor.sv]
`timescale 1ns/1ns
`default_nettype none
// ==========================================================
// Checker on the command pins and status outputs
// ==========================================================
module sbcl_legality_monitor #(
  parameter int PRE_CYC = 1,
  parameter int ACT_CYC = 1,
  parameter int RFC_CYC = 1,
  parameter int MRD_CYC = 1
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic rstn,
  input wire logic ce,
  // Command pins
  input wire logic memClkEn,
  input wire logic chipSelN,
  input wire logic rasN,
  input wire logic casN,
  input wire logic weN,
  input wire logic bankSelectLow,
  input wire logic bankSelectHigh,
  input wire logic autoPrechargeAddressBit,
  // Status
  input wire logic [4*3-1:0] bankState,
  input wire logic [2:0] deviceState,
  input wire logic burstBank,
  input wire logic [1:0] lastReadBank,
  input wire logic dataInvalid,
  input wire logic protocolError,
  input wire logic cmdAccepted
);
  import sbcl_pkg::*;
  logic [2:0] cmd;
  logic [2:0] lastCmd;
  logic [1:0] lastBank;
  logic lastAp;
  assign cmd = {rasN, casN, weN};
  // Pins of the previous edge, so a pulse can be tied to its cause
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      lastCmd <= CMD_NOP;
      lastBank <= 2'h0;
      lastAp <= 1'b0;
    end else begin
      lastCmd <= cmd;
      lastBank <= {bankSelectHigh, bankSelectLow};
      lastAp <= autoPrechargeAddressBit;
    end
  end
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rstn);
  // Answers only ever follow a real command
  a_deselect_quiet: assert property (
    chipSelN |=> !cmdAccepted && !protocolError)
    else $error("answer while deselected");
  a_nop_quiet: assert property (
    !chipSelN && cmd == CMD_NOP |=> !cmdAccepted && !protocolError)
    else $error("answer to no-operation");
  // Guarded on a quiet previous cycle, as bankState lags one edge
  a_dpd_entry: assert property (
    ce && $past(rstn) && $past(memClkEn) && !memClkEn && !chipSelN &&
    cmd == CMD_BST && bankState == 12'h000 && !cmdAccepted &&
    deviceState == SBCL_DEV_NORMAL |-> ##[1:2]
    (deviceState == SBCL_DEV_DEEP_PD && dataInvalid))
    else $error("deep power-down not entered");
  a_act_shows: assert property (
    cmdAccepted && lastCmd == CMD_ACT |=>
    bankState[$past(lastBank)*3 +: 3] == SBCL_ACTIVATING)
    else $error("activate not tracked");
  a_read_tracked: assert property (
    cmdAccepted && lastCmd == CMD_RD && !lastAp |=>
    lastReadBank == $past(lastBank) &&
    bankState[$past(lastBank)*3 +: 3] == SBCL_READ && burstBank)
    else $error("read not tracked");
  a_ap_read: assert property (
    cmdAccepted && lastCmd == CMD_RD && lastAp |=>
    bankState[$past(lastBank)*3 +: 3] == SBCL_READ_AP)
    else $error("auto precharge read not tracked");
  a_pre_all: assert property (
    cmdAccepted && lastCmd == CMD_PRE && lastAp |=>
    deviceState == SBCL_DEV_PRE_ALL)
    else $error("precharge all not entered");
  // deviceState lags one edge, so it is read one cycle after the command
  a_busy_refuse: assert property (
    !chipSelN && cmd != CMD_NOP ##1 deviceState != SBCL_DEV_NORMAL
    |-> !cmdAccepted)
    else $error("command taken while device busy");
endmodule
bind sbcl_command_legality sbcl_legality_monitor #(.PRE_CYC(PRE_CYC),
  .ACT_CYC(ACT_CYC), .RFC_CYC(RFC_CYC), .MRD_CYC(MRD_CYC)) mon (
  .mclk(mclk), .rstn(rstn), .ce(ce), .memClkEn(memClkEn),
  .chipSelN(chipSelN), .rasN(rasN), .casN(casN), .weN(weN),
  .bankSelectLow(bankSelectLow), .bankSelectHigh(bankSelectHigh),
  .autoPrechargeAddressBit(autoPrechargeAddressBit),
  .bankState(bankState), .deviceState(deviceState), .burstBank(burstBank),
  .lastReadBank(lastReadBank), .dataInvalid(dataInvalid),
  .protocolError(protocolError), .cmdAccepted(cmdAccepted));
`default_nettype wire

// [sbcl_ctrl_model.sv]
`timescale 1ns/1ns
`default_nettype none
// ==========================================================
// Behavioural memory controller on the command pins
// ==========================================================
module sbcl_ctrl_model (
  // Clock
  input wire logic mclk,
  // Command pins
  output logic memClkEn,
  output logic chipSelN,
  output logic rasN,
  output logic casN,
  output logic weN,
  output logic bankSelectLow,
  output logic bankSelectHigh,
  output logic autoPrechargeAddressBit
);
  // Deselected with clock enable high from time zero
  initial begin
    memClkEn = 1'b1;
    chipSelN = 1'b1;
    {rasN, casN, weN} = 3'h7;
    {bankSelectHigh, bankSelectLow} = 2'h0;
    autoPrechargeAddressBit = 1'b0;
  end
  // One command held for one edge, then inverted pins while
  // deselected so a stale command can never pass as a new one
  task automatic issue(input logic [2:0] c, input logic [1:0] b,
    input logic ap, input logic cke);
    @(posedge mclk);
    memClkEn <= cke;
    chipSelN <= 1'b0;
    {rasN, casN, weN} <= c;
    {bankSelectHigh, bankSelectLow} <= b;
    autoPrechargeAddressBit <= ap;
    @(posedge mclk);
    chipSelN <= 1'b1;
    {rasN, casN, weN} <= ~c;
    {bankSelectHigh, bankSelectLow} <= ~b;
    autoPrechargeAddressBit <= ~ap;
  endtask
endmodule
`default_nettype wire

// [sbcl_command_legality_test.sv]
`timescale 1ns/1ns
`default_nettype none
module sbcl_command_legality_test;
  import sbcl_pkg::*;
  // Longer minimum times so busy banks can be hit
  localparam int ACT = 4;
  localparam int PRE = 4;
  logic mclk = 1'b0;
  logic rstn = 1'b0;
  logic ce = 1'b1;
  logic memClkEn, chipSelN, rasN, casN, weN;
  logic bankSelectLow, bankSelectHigh, autoPrechargeAddressBit;
  logic [11:0] bankState;
  logic [2:0] deviceState;
  logic [1:0] lastReadBank;
  logic burstBank, dataInvalid, protocolError, cmdAccepted;
  int errors = 0;
  int checked = 0;
  // ========================================================
  // Clock, partner and design
  // ========================================================
  always #50 mclk = ~mclk;
  sbcl_ctrl_model m (.mclk(mclk), .memClkEn(memClkEn),
    .chipSelN(chipSelN), .rasN(rasN), .casN(casN), .weN(weN),
    .bankSelectLow(bankSelectLow), .bankSelectHigh(bankSelectHigh),
    .autoPrechargeAddressBit(autoPrechargeAddressBit));
  sbcl_command_legality #(.PRE_CYC(PRE), .ACT_CYC(ACT)) dut (
    .mclk(mclk), .rstn(rstn), .ce(ce), .memClkEn(memClkEn),
    .chipSelN(chipSelN), .rasN(rasN), .casN(casN), .weN(weN),
    .bankSelectLow(bankSelectLow), .bankSelectHigh(bankSelectHigh),
    .autoPrechargeAddressBit(autoPrechargeAddressBit),
    .bankState(bankState), .deviceState(deviceState),
    .burstBank(burstBank), .lastReadBank(lastReadBank),
    .dataInvalid(dataInvalid), .protocolError(protocolError),
    .cmdAccepted(cmdAccepted));
  // ========================================================
  // Helpers
  // ========================================================
  task automatic check(input string what, input logic [11:0] seen,
    input logic [11:0] exp);
    checked++;
    if (seen !== exp) begin
      errors++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic stop_test;
    $display("checked %0d errors %0d", checked, errors);
    if (errors == 0 && checked > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  task automatic wait_n(input int n);
    repeat (n) @(negedge mclk);
  endtask
  function automatic logic [2:0] st(input int b);
    return bankState[b*3 +: 3];
  endfunction
  // One command, then its answer pulse one cycle later
  task automatic go(input logic [2:0] c, input logic [1:0] b,
    input logic ap, input logic acc);
    m.issue(c, b, ap, 1'b1);
    @(negedge mclk);
    check("accepted", cmdAccepted, acc);
    check("error", protocolError, !acc);
  endtask
  // ========================================================
  // Scenarios
  // ========================================================
  task automatic t_bank_life;
    check("resetInvalid", dataInvalid, 1'b1);
    go(CMD_ACT, 2'h1, 1'b0, 1'b1);
    go(CMD_RD, 2'h1, 1'b0, 1'b0);
    wait_n(ACT + 2);
    check("active", st(1), SBCL_ACTIVE);
    go(CMD_RD, 2'h1, 1'b0, 1'b1);
    wait_n(1);
    check("readBank", lastReadBank, 2'h1);
    check("reading", st(1), SBCL_READ);
    check("burst", burstBank, 1'b1);
    go(CMD_BST, 2'h2, 1'b0, 1'b1);
    // One cycle later only the terminate can have closed the burst
    wait_n(1);
    check("stopped", st(1), SBCL_ACTIVE);
    check("noBurst", burstBank, 1'b0);
  endtask
  // Write burst cut by a read, then by a precharge
  task automatic t_write;
    go(CMD_WR, 2'h1, 1'b0, 1'b1);
    // Trailing write data masking lives on the data path
    go(CMD_RD, 2'h1, 1'b0, 1'b1);
    wait_n(8);
    check("rowOpen", st(1), SBCL_ACTIVE);
    go(CMD_RD, 2'h1, 1'b0, 1'b1);
    go(CMD_BST, 2'h1, 1'b0, 1'b1);
    go(CMD_WR, 2'h1, 1'b0, 1'b1);
    go(CMD_PRE, 2'h1, 1'b0, 1'b1);
    wait_n(PRE + 2);
    check("closed", st(1), SBCL_IDLE);
  endtask
  task automatic t_other_banks;
    go(CMD_ACT, 2'h0, 1'b0, 1'b1);
    go(CMD_ACT, 2'h3, 1'b0, 1'b1);
    wait_n(ACT + 2);
    go(CMD_RD, 2'h0, 1'b0, 1'b1);
    go(CMD_RD, 2'h3, 1'b0, 1'b1);
    wait_n(1);
    check("newReadBank", lastReadBank, 2'h3);
    check("replaced", st(0), SBCL_ACTIVE);
    go(CMD_PRE, 2'h1, 1'b1, 1'b1);
    go(CMD_ACT, 2'h1, 1'b0, 1'b0);
    check("preAll", deviceState, SBCL_DEV_PRE_ALL);
    wait_n(PRE + 2);
    check("allIdle", bankState, 12'h000);
  endtask
  task automatic t_device;
    go(CMD_REF, 2'h0, 1'b0, 1'b1);
    wait_n(1);
    check("refresh", deviceState, SBCL_DEV_REFRESH);
    wait_n(2);
    go(CMD_LMR, 2'h0, 1'b0, 1'b1);
    wait_n(3);
    check("dataValid", dataInvalid, 1'b0);
    go(CMD_ACT, 2'h2, 1'b0, 1'b1);
    wait_n(ACT + 2);
    go(CMD_REF, 2'h0, 1'b0, 1'b0);
    go(CMD_RD, 2'h2, 1'b1, 1'b1);
    wait_n(1);
    check("readAp", st(2), SBCL_READ_AP);
    // Three frozen edges push the return to idle three cycles out
    @(posedge mclk);
    ce <= 1'b0;
    repeat (3) @(posedge mclk);
    ce <= 1'b1;
    wait_n(5);
    check("frozen", st(2), SBCL_READ_AP);
    wait_n(4);
    check("apIdle", st(2), SBCL_IDLE);
  endtask
  // Deep power-down entry, lost data, exit and the mode reload after it
  task automatic t_deep_pd;
    m.issue(CMD_BST, 2'h0, 1'b0, 1'b0);
    wait_n(2);
    check("deepPd", deviceState, SBCL_DEV_DEEP_PD);
    check("lost", dataInvalid, 1'b1);
    // Leave with a no-operation, then reload the mode before any access
    m.issue(CMD_NOP, 2'h0, 1'b0, 1'b1);
    @(negedge mclk);
    check("firstEdge", cmdAccepted, 1'b0);
    wait_n(2);
    check("awake", deviceState, SBCL_DEV_NORMAL);
    go(CMD_LMR, 2'h0, 1'b0, 1'b1);
    go(CMD_ACT, 2'h0, 1'b0, 1'b1);
  endtask
  // ========================================================
  // Main sequence and watchdog
  // ========================================================
  initial begin
    repeat (2) @(posedge mclk);
    rstn <= 1'b1;
    @(negedge mclk);
    t_bank_life;
    t_write;
    t_other_banks;
    t_device;
    t_deep_pd;
    stop_test;
  end
  // Far beyond the hundred or so cycles the scenarios take
  initial begin
    repeat (3000) @(posedge mclk);
    errors++;
    stop_test;
  end
endmodule
`default_nettype wire
